// *** core/sdcg_pkg.sv ***
// Package: shared types and constants of the SDRAM command and clock-gate front end.
// Assumes one 100 MHz core clock; all pins are synchronous to it except CKE in power-down and self refresh.
package sdcg_pkg;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam longint REFRESH_WINDOW_NS = 64000000;
	localparam int REFRESH_ROWS = 8192;
	// Longest spacing, so rounded down
	localparam int REFRESH_STEP_CYC = int'(REFRESH_WINDOW_NS / (REFRESH_ROWS * CLK_PERIOD_NS));
	// ==========================================
	// Field positions and codes
	localparam int AP_BIT = 10;
	localparam int COL_W = 9;
	localparam int ROW_W = 13;
	localparam int DQ_W = 16;
	localparam int PIPE_N = 3;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [9:0] TIMER_RESET = 10'h000;
	// ==========================================
	// Types
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_PDOWN = 3'b010,
		ST_SELF = 3'b100
	} sdcg_pwr_t;
	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [1:0] bankSelect;
		logic [ROW_W-1:0] addr;
	} sdcg_cmd_t;
	typedef struct packed {
		sdcg_pwr_t pwr;
		logic ckeLast;
		logic ckeS1;
		logic ckeS2;
		logic [3:0] bankOpen;
		logic burstOn;
		logic burstWr;
		logic autoPre;
		logic [1:0] burstBank;
		logic [COL_W-1:0] startCol;
		logic [COL_W-1:0] burstIdx;
		logic [PIPE_N-1:0] pipeV;
		logic [PIPE_N-1:0][DQ_W-1:0] pipeD;
		logic [ROW_W-1:0] refreshRow;
		logic [9:0] selfTimer;
	} sdcg_state_t;
	localparam sdcg_state_t STATE_RESET = '{pwr: ST_RUN, ckeLast: 1'b1, ckeS1: 1'b0,
		ckeS2: 1'b0, refreshRow: 13'h0000, selfTimer: TIMER_RESET, default: '0};
endpackage : sdcg_pkg

// *** core/sdram_command_clock_gate.sv ***
// Design: write-data FIFO and the SDRAM command decoder with clock-enable gating.
// Assumes the controller drives pins synchronous to core_clk and keeps its timing rules.

// ==========================================
// Write-data FIFO
module sdcg_fifo
	import sdcg_pkg::*;
#(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] rdPtr;
		logic [AW-1:0] wrPtr;
		logic [AW:0] count;
	} sdcg_fifo_state_t;
	sdcg_fifo_state_t s, next_s;
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic push, pop;

	// Full and empty come straight from the word count
	assign inReady = (s.count != (AW+1)'(DEPTH));
	assign outValid = (s.count != '0);
	assign outData = mem[s.rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Pointer and count update
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.wrPtr = s.wrPtr + 1'b1;
		end
		if (pop) begin
			next_s.rdPtr = s.rdPtr + 1'b1;
		end
		next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Storage needs no reset; only counted words are read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[s.wrPtr] <= inData;
		end
	end
endmodule : sdcg_fifo

// ==========================================
// Command decoder and clock gate
module sdram_command_clock_gate
	import sdcg_pkg::*;
#(
	parameter int MEM_COL_W = 4,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cke,
	input wire sdcg_cmd_t cmd,
	input wire logic [DQ_W-1:0] dqIn,
	input wire logic casLatency3,
	input wire logic [2:0] burstLen,
	input wire logic burstInterleave,
	input wire logic storeHold,
	output logic [DQ_W-1:0] dqOut,
	output logic dqOe,
	output logic [3:0] bankActive,
	output logic powerDown,
	output logic selfRefresh,
	output logic [ROW_W-1:0] refreshRow,
	output logic wrBufReady
);
	localparam int FW = 2 + MEM_COL_W + DQ_W;

	// Last burst offset for a length code; full page spans the row
	function automatic logic [COL_W-1:0] sdcg_last(input logic [2:0] code);
		case (code)
			BL_1: sdcg_last = 9'h000;
			BL_2: sdcg_last = 9'h001;
			BL_4: sdcg_last = 9'h003;
			BL_8: sdcg_last = 9'h007;
			default: sdcg_last = 9'h1ff;
		endcase
	endfunction : sdcg_last

	// Column of a burst word: upper bits fixed, low bits wrap or interleave
	function automatic logic [COL_W-1:0] sdcg_col(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] idx, input logic [2:0] code, input logic inter);
		logic [COL_W-1:0] m;
		m = sdcg_last(code);
		if (inter) begin
			sdcg_col = (start & ~m) | ((start ^ idx) & m);
		end else begin
			sdcg_col = (start & ~m) | ((start + idx) & m);
		end
	endfunction : sdcg_col

	sdcg_state_t s, next_s;
	logic [DQ_W-1:0] mem [0:(4 << MEM_COL_W)-1];
	logic running, cmdRow, cmdPre, cmdCol, cmdStop, cmdRef, allIdle;
	logic wordOn, wrValid, rdPop;
	logic [COL_W-1:0] wordCol, nextIdx;
	logic [1:0] wordBank;
	logic [FW-1:0] wrData, rdData;

	// Internal clock is live for an edge only if CKE was high the edge before
	assign running = (s.pwr == ST_RUN) && s.ckeLast;
	// Chip select high masks every command
	assign cmdRow = !cmd.csN && !cmd.rasN && cmd.casN && cmd.weN;
	assign cmdPre = !cmd.csN && !cmd.rasN && cmd.casN && !cmd.weN;
	assign cmdCol = !cmd.csN && cmd.rasN && !cmd.casN;
	assign cmdStop = !cmd.csN && cmd.rasN && cmd.casN && !cmd.weN;
	assign cmdRef = !cmd.csN && !cmd.rasN && !cmd.casN && cmd.weN;
	assign allIdle = (s.bankOpen == 4'h0) && !s.burstOn;
	assign nextIdx = s.burstIdx + 1'b1;

	// Main next-state logic
	always_comb begin
		next_s = s;
		wordOn = 1'b0;
		wordCol = '0;
		wordBank = s.burstBank;
		next_s.ckeS1 = cke;
		next_s.ckeS2 = s.ckeS1;
		case (s.pwr)
			ST_PDOWN, ST_SELF: begin
				// Pins other than CKE are not looked at here
				if (s.pwr == ST_SELF) begin
					next_s.selfTimer = s.selfTimer + 1'b1;
					if (s.selfTimer == 10'(REFRESH_STEP_CYC - 1)) begin
						next_s.selfTimer = TIMER_RESET;
						next_s.refreshRow = s.refreshRow + 1'b1;
					end
				end
				if (s.ckeS2) begin
					next_s.pwr = ST_RUN;
					next_s.ckeLast = 1'b1;
				end
			end
			ST_RUN: begin
				next_s.ckeLast = cke;
				if (running) begin
					// Read pipeline advances one stage per live edge
					next_s.pipeV = {1'b0, s.pipeV[PIPE_N-1:1]};
					next_s.pipeD = {16'h0000, s.pipeD[PIPE_N-1:1]};
					if (s.burstOn) begin
						wordOn = 1'b1;
						wordCol = sdcg_col(s.startCol, nextIdx, burstLen, burstInterleave);
						next_s.burstIdx = nextIdx;
						if (nextIdx == sdcg_last(burstLen)) begin
							next_s.burstOn = 1'b0;
							if (s.autoPre) begin
								next_s.bankOpen[s.burstBank] = 1'b0;
							end
						end
					end
					// Entry flushes the synchroniser; its second stage still holds the
					// high level of the previous edge and would end the mode at once
					if (!cke && allIdle && cmd.csN) begin
						next_s.pwr = ST_PDOWN;
						next_s.ckeS2 = 1'b0;
					end else if (!cke && allIdle && cmdRef) begin
						next_s.pwr = ST_SELF;
						next_s.ckeS2 = 1'b0;
						next_s.selfTimer = TIMER_RESET;
					end else if (cmdRow) begin
						next_s.bankOpen[cmd.bankSelect] = 1'b1;
					end else if (cmdPre) begin
						if (cmd.addr[AP_BIT]) begin
							next_s.bankOpen = 4'h0;
						end else begin
							next_s.bankOpen[cmd.bankSelect] = 1'b0;
						end
					end else if (cmdStop) begin
						next_s.burstOn = 1'b0;
						wordOn = 1'b0;
					end else if (cmdRef && allIdle) begin
						next_s.refreshRow = s.refreshRow + 1'b1;
					end else if (cmdCol && s.bankOpen[cmd.bankSelect]) begin
						// A row must be open first; a column command to idle bank is dropped
						wordOn = 1'b1;
						wordBank = cmd.bankSelect;
						wordCol = sdcg_col(cmd.addr[COL_W-1:0], 9'h000, burstLen, burstInterleave);
						next_s.burstWr = !cmd.weN;
						next_s.burstBank = cmd.bankSelect;
						next_s.startCol = cmd.addr[COL_W-1:0];
						next_s.burstIdx = 9'h000;
						next_s.autoPre = cmd.addr[AP_BIT];
						next_s.burstOn = (burstLen != BL_1);
						if (burstLen == BL_1 && cmd.addr[AP_BIT]) begin
							next_s.bankOpen[cmd.bankSelect] = 1'b0;
						end
					end
					// Read words enter the pipe so they leave after the latency
					if (wordOn && !next_s.burstWr) begin
						next_s.pipeV[casLatency3 ? 2 : 1] = 1'b1;
						next_s.pipeD[casLatency3 ? 2 : 1] = mem[{wordBank, wordCol[MEM_COL_W-1:0]}];
					end
				end
			end
			default: begin
				next_s.pwr = ST_RUN;
			end
		endcase
	end

	// Sampling every pin on the core clock edge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Write words are queued; a full queue drops them and shows it on wrBufReady
	assign wrValid = wordOn && next_s.burstWr;
	assign wrData = {wordBank, wordCol[MEM_COL_W-1:0], dqIn};

	sdcg_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.inValid(wrValid),
		.inReady(wrBufReady),
		.inData(wrData),
		.outValid(rdPop),
		.outReady(!storeHold),
		.outData(rdData)
	);

	// Storage drain; storeHold stalls it so the queue can fill
	always_ff @(posedge core_clk) begin
		if (rdPop && !storeHold) begin
			mem[rdData[FW-1:DQ_W]] <= rdData[DQ_W-1:0];
		end
	end

	// Outputs all from state flops, so they freeze with the state
	assign dqOut = s.pipeD[0];
	assign dqOe = s.pipeV[0];
	assign bankActive = s.bankOpen;
	assign powerDown = (s.pwr == ST_PDOWN);
	assign selfRefresh = (s.pwr == ST_SELF);
	assign refreshRow = s.refreshRow;

	// ==========================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_cs_mask;
		running && cmd.csN && !s.burstOn && cke |=> $stable(s.bankOpen);
	endproperty
	a_cs_mask: assert property (p_cs_mask) else $error("command taken with chip select high");

	property p_row_open;
		running && cmdRow && !(!cke && allIdle) |=> s.bankOpen[$past(cmd.bankSelect)];
	endproperty
	a_row_open: assert property (p_row_open) else $error("row open missed its bank");

	property p_precharge;
		running && cmdPre && !cmd.addr[AP_BIT] |=> !s.bankOpen[$past(cmd.bankSelect)];
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge left bank open");

	property p_cl2;
		running && cmdCol && cmd.weN && !casLatency3 && s.bankOpen[cmd.bankSelect] && cke
			|-> ##2 dqOe;
	endproperty
	a_cl2: assert property (p_cl2) else $error("read word not out at latency two");

	property p_cl3;
		running && cmdCol && cmd.weN && casLatency3 && s.bankOpen[cmd.bankSelect] && cke
			##1 cke |-> ##2 dqOe;
	endproperty
	a_cl3: assert property (p_cl3) else $error("read word not out at latency three");

	property p_freeze;
		s.pwr == ST_RUN && !s.ckeLast |=> $stable(s.burstIdx) && $stable(dqOut) && $stable(dqOe);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while suspended");

	property p_burst_end;
		running && s.burstOn && nextIdx == sdcg_last(burstLen) |=> !s.burstOn;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst overran its length");

	property p_auto_pre;
		running && s.burstOn && s.autoPre && nextIdx == sdcg_last(burstLen) && !cmdRow
			|=> !s.bankOpen[$past(s.burstBank)];
	endproperty
	a_auto_pre: assert property (p_auto_pre) else $error("auto precharge did not close row");

	property p_pd_idle;
		$rose(powerDown) || $rose(selfRefresh) |-> $past(s.bankOpen) == 4'h0;
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("low power entered with bank open");

	property p_pd_hold;
		powerDown && !s.ckeS2 |=> powerDown && $stable(s.bankOpen);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("pins acted on in power-down");

	property p_pd_exit;
		powerDown && cke ##1 cke |-> ##[1:2] !powerDown;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("power-down exit too slow");

	c_read: cover property (running && cmdCol && cmd.weN ##[1:4] dqOe);
	c_write: cover property (wrValid ##1 wrValid);
	c_pdown: cover property ($rose(powerDown) ##[1:20] !powerDown);
	c_self: cover property ($rose(selfRefresh));
endmodule : sdram_command_clock_gate

// *** test/sdcg_host.sv ***
// Host controller model: drives command pins, clock enable and write data.
// Assumes one core clock; the bench sequences commands through its tasks.
module sdcg_host
	import sdcg_pkg::*;
(
	input wire logic core_clk,
	output sdcg_cmd_t cmd,
	output logic cke,
	output logic [DQ_W-1:0] dqIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Start deselected with the clock enabled
	initial begin
		cmd = '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, default: '0};
		cke = 1'b1;
		dqIn = 16'h0000;
	end
	// Pins change just after an edge and hold through the next sampling edge
	task automatic send(input logic [3:0] op, input logic [1:0] bank,
		input logic [ROW_W-1:0] addr, input logic [DQ_W-1:0] data, input logic ck = 1'b1);
		@(posedge core_clk);
		cmd <= '{csN: op[3], rasN: op[2], casN: op[1], weN: op[0],
			bankSelect: bank, addr: addr};
		cke <= ck;
		dqIn <= data;
	endtask : send
	// Deselect with random strobes, bank and address; data toggles so a stale word never looks driven
	task automatic idle(input int n, input logic ck = 1'b1);
		repeat (n) send({1'b1, 3'($urandom)}, 2'($urandom), 13'($urandom), ~dqIn, ck);
	endtask : idle
endmodule : sdcg_host

// *** test/test_sdram_command_clock_gate.sv ***
// Self-checking bench of the SDRAM command front end driven by a host model.
// Assumes the package, design and host model are compiled before this file.
module test_sdram_command_clock_gate
	import sdcg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [DQ_W-1:0] d; int t;} sdcg_exp_t;
	localparam logic [3:0] ROW = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4, REF = 4'h1;
	logic core_clk, nrst, cke, casLatency3, burstInterleave, storeHold, lastOe;
	logic dqOe, powerDown, selfRefresh, wrBufReady;
	logic liveLast = 1'b1;
	logic ckeWas = 1'b1;
	logic curIl = 1'b0;
	logic [2:0] burstLen;
	logic [3:0] bankActive;
	logic [DQ_W-1:0] dqIn, dqOut, lastOut;
	logic [ROW_W-1:0] refreshRow, r0;
	logic [DQ_W-1:0] mem [4][16];
	sdcg_cmd_t cmd;
	sdcg_exp_t expQ[$];
	sdcg_exp_t e;
	int live = 0, curCl = 2, curN = 1, err_count = 0, tests_run = 0;

	sdcg_host sdcg_host_i (.core_clk(core_clk), .cmd(cmd), .cke(cke), .dqIn(dqIn));
	sdram_command_clock_gate sdram_command_clock_gate_i (.core_clk(core_clk), .nrst(nrst),
		.cke(cke), .cmd(cmd), .dqIn(dqIn), .casLatency3(casLatency3), .burstLen(burstLen),
		.burstInterleave(burstInterleave), .storeHold(storeHold), .dqOut(dqOut), .dqOe(dqOe),
		.bankActive(bankActive), .powerDown(powerDown), .selfRefresh(selfRefresh),
		.refreshRow(refreshRow), .wrBufReady(wrBufReady));

	// ==========================================
	// Clock; counts live edges, since a frozen edge must not advance a burst
	initial begin
		core_clk = 1'b0;
		forever begin
			#5 core_clk = ~core_clk;
			if (core_clk) begin
				liveLast = ckeWas;
				if (ckeWas) live++;
				ckeWas = cke;
			end
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Mode levels are set one edge ahead of the column command
	task automatic cfg(input logic cl3, input logic [2:0] bl, input logic il);
		sdcg_host_i.idle(1);
		casLatency3 <= cl3;
		burstLen <= bl;
		burstInterleave <= il;
		curCl = cl3 ? 3 : 2;
		curN = (bl == BL_PAGE) ? 512 : 1 << bl;
		curIl = il;
	endtask : cfg
	function automatic logic [8:0] bcol(input logic [8:0] c, input int k);
		logic [8:0] m;
		m = 9'(curN - 1);
		return (c & ~m) | ((curIl ? c ^ 9'(k) : c + 9'(k)) & m);
	endfunction : bcol
	task automatic wr(input logic [1:0] b, input logic [8:0] c);
		logic [8:0] col;
		logic [15:0] d;
		for (int k = 0; k < curN; k++) begin
			d = 16'($urandom);
			col = bcol(c, k);
			mem[b][col[3:0]] = d;
			if (k == 0)
				sdcg_host_i.send(WR, b, {2'($urandom), 1'b0, 1'($urandom), c}, d);
			else
				sdcg_host_i.send(4'hf, 2'h0, 13'h0000, d);
		end
	endtask : wr
	// Notes each word with the live edge count after which it must show
	task automatic rd(input logic [1:0] b, input logic [8:0] c, input logic ap, input int nw = 512);
		logic [8:0] col;
		sdcg_host_i.send(RD, b, {2'($urandom), ap, 1'($urandom), c}, ~dqIn);
		for (int k = 0; k < curN && k < nw; k++) begin
			col = bcol(c, k);
			expQ.push_back('{mem[b][col[3:0]], live + curCl + k});
		end
	endtask : rd

	// ==========================================
	// Read watcher; also checks that frozen edges leave the outputs alone
	always @(negedge core_clk) begin
		if (nrst === 1'b1 && dqOe === 1'b1 && liveLast) begin
			chk(32'(expQ.size() != 0), 32'h1, "word expected");
			if (expQ.size() != 0) begin
				e = expQ.pop_front();
				chk(32'(dqOut), 32'(e.d), "read data");
				chk(32'(live), 32'(e.t), "read latency");
			end
		end
		if (nrst === 1'b1 && !liveLast)
			chk(32'({dqOe, dqOut}), 32'({lastOe, lastOut}), "held output");
		lastOe = dqOe;
		lastOut = dqOut;
	end
	// Watchdog sized well above the expected run of about 1100 cycles
	initial begin
		repeat (6000) @(posedge core_clk);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end

	// ==========================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		casLatency3 = 1'b0;
		burstLen = BL_1;
		burstInterleave = 1'b0;
		storeHold = 1'b0;
		void'($urandom(29680));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		chk(32'({bankActive, dqOe, powerDown, selfRefresh, wrBufReady, refreshRow}),
			32'h2000, "reset");
		tdone("reset");
		for (int b = 0; b < 4; b++) begin
			sdcg_host_i.send(4'hb, 2'(b + 1), 13'h0000, ~dqIn);
			sdcg_host_i.send(ROW, 2'(b), 13'($urandom), ~dqIn);
			sdcg_host_i.idle(1);
			@(negedge core_clk);
			chk(32'(bankActive), (32'h2 << b) - 1, "row open");
		end
		sdcg_host_i.send(PRE, 2'h2, 13'h0000, ~dqIn);
		sdcg_host_i.idle(1);
		@(negedge core_clk);
		chk(32'(bankActive), 32'hb, "precharge");
		tdone("banks");
		cfg(1'b0, BL_8, 1'b0);
		wr(2'h1, 9'h000);
		wr(2'h1, 9'h008);
		sdcg_host_i.idle(4);
		// Burst lengths 1, 2, 4 and 8 with both latencies; sequential for 1 and 8, interleaved for 2 and 4
		for (int i = 0; i < 8; i++) begin
			cfg(i[0], 3'(i >> 1), i[1] ^ i[2]);
			rd(2'h1, 9'($urandom), 1'b0);
			sdcg_host_i.idle(14);
		end
		chk(32'(expQ.size()), 32'h0, "all words seen");
		cfg(1'b0, BL_2, 1'b1);
		rd(2'h1, 9'h003, 1'b1);
		sdcg_host_i.idle(6);
		@(negedge core_clk);
		chk(32'(bankActive), 32'h9, "auto precharge");
		tdone("burst");
		// Suspend mid-burst with a bank open: no low-power entry
		sdcg_host_i.send(ROW, 2'h1, 13'h0000, ~dqIn);
		cfg(1'b1, BL_8, 1'b0);
		rd(2'h1, 9'h005, 1'b0);
		sdcg_host_i.idle(4);
		sdcg_host_i.idle(3, 1'b0);
		@(negedge core_clk);
		chk(32'(powerDown), 32'h0, "suspend only");
		sdcg_host_i.idle(12);
		chk(32'(expQ.size()), 32'h0, "suspended burst");
		tdone("suspend");
		sdcg_host_i.send(PRE, 2'h0, 13'h0400, ~dqIn);
		sdcg_host_i.idle(1);
		@(negedge core_clk);
		r0 = refreshRow;
		sdcg_host_i.send(REF, 2'h0, 13'h0000, ~dqIn);
		sdcg_host_i.idle(2);
		@(negedge core_clk);
		chk(32'(bankActive), 32'h0, "precharge all");
		chk(32'(refreshRow), 32'(r0 + 1'b1), "auto refresh");
		sdcg_host_i.idle(2, 1'b0);
		sdcg_host_i.send(ROW, 2'h0, 13'h0000, ~dqIn, 1'b0);
		sdcg_host_i.idle(4, 1'b0);
		@(negedge core_clk);
		chk(32'(powerDown), 32'h1, "power down");
		sdcg_host_i.idle(3);
		@(negedge core_clk);
		chk(32'(powerDown), 32'h1, "exit pending");
		sdcg_host_i.idle(1);
		@(negedge core_clk);
		chk(32'({powerDown, bankActive}), 32'h0, "exit");
		sdcg_host_i.send(REF, 2'h0, 13'h0000, ~dqIn, 1'b0);
		sdcg_host_i.idle(2, 1'b0);
		@(negedge core_clk);
		r0 = refreshRow;
		chk(32'(selfRefresh), 32'h1, "self refresh");
		sdcg_host_i.idle(REFRESH_STEP_CYC + 10, 1'b0);
		@(negedge core_clk);
		chk(32'(refreshRow), 32'(r0 + 1'b1), "timed refresh");
		sdcg_host_i.idle(4);
		@(negedge core_clk);
		chk(32'(selfRefresh), 32'h0, "self refresh exit");
		tdone("low power");
		// Fill the write buffer with storage stalled, then drain and read back
		sdcg_host_i.send(ROW, 2'h2, 13'h0000, ~dqIn);
		cfg(1'b0, BL_8, 1'b0);
		storeHold <= 1'b1;
		wr(2'h2, 9'h000);
		wr(2'h2, 9'h008);
		sdcg_host_i.idle(2);
		@(negedge core_clk);
		chk(32'(wrBufReady), 32'h0, "buffer full");
		sdcg_host_i.idle(1);
		storeHold <= 1'b0;
		sdcg_host_i.idle(20);
		chk(32'(wrBufReady), 32'h1, "buffer drained");
		rd(2'h2, 9'h004, 1'b0);
		sdcg_host_i.idle(14);
		chk(32'(expQ.size()), 32'h0, "buffered words");
		tdone("buffer");
		// Full page read cut short by a burst stop after five words
		cfg(1'b0, BL_PAGE, 1'b0);
		rd(2'h2, 9'h00c, 1'b0, 5);
		sdcg_host_i.idle(4);
		sdcg_host_i.send(4'h6, 2'h0, 13'h0000, ~dqIn);
		sdcg_host_i.idle(10);
		chk(32'(expQ.size()), 32'h0, "burst stop");
		tdone("stop");
		complete_run();
	end
endmodule : test_sdram_command_clock_gate
